/* rtl/timer_pkg.sv */
// Constants shared by the timer core and its counter blocks
package timer_pkg;
	localparam logic [7:0] OFS_BUCFG = 8'h00;
	localparam logic [7:0] OFS_PSCTL = 8'h08;
	localparam logic [7:0] OFS_FCTL = 8'h10;
	localparam logic [7:0] OFS_FCNT = 8'h14;
	localparam logic [7:0] OFS_MCTL = 8'h18;
	localparam logic [7:0] OFS_MCNT = 8'h1C;
	localparam logic [7:0] OFS_MLAT = 8'h20;
	// bus_unit_config_reg fields
	localparam int BU_FRZ = 15;
	localparam int BU_VECT = 6;
	localparam int BU_IARB = 0;
	// prescaler_control_reg fields
	localparam int PS_RUN = 3;
	localparam int PS_DIV = 0;
	// Counter control register fields
	localparam int CT_COF = 15;
	localparam int CT_IL = 12;
	localparam int CT_ARB3 = 11;
	localparam int CT_DRIVE_BUS_B_BIT = 9;
	localparam int CT_DRIVE_BUS_A_BIT = 8;
	localparam int CT_PIN = 7;
	localparam int CT_PIN1 = 6;
	localparam int CT_EDGE = 4;
	localparam int CT_CLK = 0;
	// Reset values and counter top value
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	// Clock select codes above the six prescaler taps
	localparam logic [2:0] CLK_RISE = 3'h6;
	localparam logic [2:0] CLK_FALL = 3'h7;
	// Load edge codes
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	// Submodule numbers used as low vector bits
	localparam logic [5:0] FC_NUM = 6'h0C;
	localparam logic [5:0] MC_NUM = 6'h0B;
	localparam int PRE_W = 9;
endpackage

/* rtl/counter_core.sv */
// Sixteen-bit up counter with clock select and optional modulus latch
`timescale 1ns/1ps
module counter_core #(
	parameter bit MODULUS = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [5:0] tick,
	input wire logic ext_rise,
	input wire logic ext_fall,
	input wire logic [2:0] clk_sel,
	input wire logic run,
	input wire logic load_evt,
	input wire logic wr_cnt,
	input wire logic wr_lat,
	input wire logic [15:0] wdata,
	output logic [15:0] count,
	output logic [15:0] latch,
	output logic ovf
);
	import timer_pkg::*;
	logic [2:0] sel_q;
	logic src;
	logic step;
	logic reload;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= 3'h0;
		end else begin
			sel_q <= clk_sel;
		end
	end

	always_comb begin
		unique case (clk_sel)
			CLK_RISE: src = ext_rise;
			CLK_FALL: src = ext_fall;
			default: src = tick[clk_sel];
		endcase
	end

	// A changing select masks the cycle, so a stale edge is never counted
	assign step = run && (sel_q == clk_sel) && src; // RULE15 RULE24
	assign reload = MODULUS && load_evt && run;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= CNT_RST; // RULE12
		end else if (wr_cnt) begin
			count <= wdata; // RULE11 RULE21
		end else if (reload) begin
			count <= latch; // RULE20
		end else if (step) begin
			if (count == CNT_MAX) begin
				count <= MODULUS ? latch : CNT_RST; // RULE20
			end else begin
				count <= count + 16'h0001; // RULE24
			end
		end
	end

	// A software write outranks the wrap, so writing zero at the top is silent
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf <= 1'b0;
		end else begin
			ovf <= !wr_cnt && !reload && step && (count == CNT_MAX); // RULE10 RULE12 RULE23
		end
	end

	generate
		if (MODULUS) begin : g_lat
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					latch <= CNT_RST;
				end else if (wr_cnt || wr_lat) begin
					latch <= wdata; // RULE21
				end
			end
		end else begin : g_nolat
			assign latch = CNT_RST;
		end
	endgenerate

	a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
		step && !wr_cnt && !reload && count != CNT_MAX |=> count == $past(count) + 16'h0001)
		else $error("counter did not advance by one"); // RULE24
	a_write_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		wr_cnt |=> !ovf && count == $past(wdata))
		else $error("write did not load or raised overflow"); // RULE12
	a_wrap_ovf: assert property (@(posedge pclk) disable iff (!presetn)
		step && !wr_cnt && !reload && count == CNT_MAX |=> ovf && count == $past(latch))
		else $error("wrap without overflow or reload"); // RULE10
	a_sel_mask: assert property (@(posedge pclk) disable iff (!presetn)
		clk_sel != sel_q && !wr_cnt && !reload |=> $stable(count))
		else $error("counted while select changed"); // RULE15
endmodule

/* rtl/timer_core.sv */
// Timer bus unit with prescaler, free-running and modulus counters
// Functional notes
// (RULE1) Processor stop leaves timer running
// (RULE2) Freeze with response bit stops all counters
// (RULE3) Pin level bits track pins while frozen
// (RULE4) Freeze disables capture, holds output flops
// (RULE5) Channel pin bit shows pin or flop
// (RULE6) Response bit clear ignores freeze
// (RULE7) Low-power halt stops the whole timer
// (RULE8) Unused bits read zero, writes ignored
// (RULE9) Prescaler gives five fixed, one selectable tap
// (RULE10) Wrap from top sets overflow flag
// (RULE11) Counter reads count, write loads it
// (RULE12) Reset zeroes; writing zero at top silent
// (RULE13) Counters wait for prescaler run bit
// (RULE14) Three-bit select picks eight clock sources
// (RULE15) Select change masks edges; pin mirrored
// (RULE16) External clock at most quarter system clock
// (RULE17) Software never drives both time buses
// (RULE18) Overflow flag plus level requests interrupt
// (RULE19) Vector is upper bits plus submodule number
// (RULE20) Modulus counter reloads on wrap or pin
// (RULE21) Counter write loads counter and latch
// (RULE22) Bus unit forwards request, level, vector
// (RULE23) Latch at top overflows every pulse
// (RULE24) Each qualified pulse adds exactly one
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
module timer_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sys_freeze,
	input wire logic ext_counter_clock_pin,
	input wire logic mod_load_pin,
	output logic submodule_freeze,
	output logic [15:0] tbb_a,
	output logic [15:0] tbb_b,
	output logic irq_req,
	output logic [2:0] irq_level,
	input wire logic iack_valid,
	input wire logic [2:0] iack_level,
	output logic iack_hit,
	output logic [3:0] iack_arb,
	output logic [7:0] iack_vector
);
	import timer_pkg::*;
	logic freeze_response_bit;
	logic [1:0] vector_upper_bits;
	logic [2:0] arbitration_field;
	logic prescaler_run_bit;
	logic [1:0] div_sel;
	logic [PRE_W-1:0] pre_cnt;
	logic [5:0] tick;
	logic run, tap6;
	logic ext_s1, ext_s2, ext_s3;
	logic ld_s1, ld_s2, ld_s3;
	logic ext_rise, ext_fall, ld_rise, ld_fall, load_evt;
	logic [2:0] fc_clk, mc_clk, fc_il, mc_il;
	logic fc_arb3, mc_arb3, fc_drive_bus_a_bit, fc_drive_bus_b_bit, mc_drive_bus_a_bit, mc_drive_bus_b_bit;
	logic [1:0] mc_edge;
	logic fc_cof, mc_cof, fc_ovf, mc_ovf;
	logic [15:0] fc_count, mc_count, mc_latch, fc_unused_lat;
	logic setup, access, wr, hit;
	logic wr_bucfg, wr_psctl, wr_fctl, wr_fcnt, wr_mctl, wr_mcnt, wr_mlat;
	logic [15:0] wd;
	logic [15:0] rd;
	logic fc_req, mc_req, fc_match, mc_match, fc_win;

	// Stop only halts the processor; no stop input gates this block
	assign submodule_freeze = sys_freeze && freeze_response_bit; // RULE1 RULE2 RULE6
	// Capture/compare and PWM channels consume submodule_freeze themselves
	// and hold their flops and status selection while it is high (RULE4 RULE5)
	// Low-power halt simply stops pclk; all state is held meanwhile (RULE7)
	assign run = prescaler_run_bit && !submodule_freeze; // RULE2 RULE13

	// APB slave: zero wait states, error on unmapped offsets
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign pready = 1'b1;
	assign wd = pwdata[15:0];
	always_comb begin
		unique case (paddr)
			OFS_BUCFG, OFS_PSCTL, OFS_FCTL, OFS_FCNT,
			OFS_MCTL, OFS_MCNT, OFS_MLAT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	assign pslverr = access && !hit;
	assign wr = access && pwrite && hit;
	assign wr_bucfg = wr && paddr == OFS_BUCFG;
	assign wr_psctl = wr && paddr == OFS_PSCTL;
	assign wr_fctl = wr && paddr == OFS_FCTL;
	assign wr_fcnt = wr && paddr == OFS_FCNT;
	assign wr_mctl = wr && paddr == OFS_MCTL;
	assign wr_mcnt = wr && paddr == OFS_MCNT;
	assign wr_mlat = wr && paddr == OFS_MLAT;

	// Read data is captured in the setup cycle so it is a flop in access
	always_comb begin
		rd = REG_RST; // RULE8
		unique case (paddr)
			OFS_BUCFG: begin
				rd[BU_FRZ] = freeze_response_bit;
				rd[BU_VECT +: 2] = vector_upper_bits;
				rd[BU_IARB +: 3] = arbitration_field;
			end
			OFS_PSCTL: begin
				rd[PS_RUN] = prescaler_run_bit;
				rd[PS_DIV +: 2] = div_sel;
			end
			OFS_FCTL: begin
				rd[CT_COF] = fc_cof;
				rd[CT_IL +: 3] = fc_il;
				rd[CT_ARB3] = fc_arb3;
				rd[CT_DRIVE_BUS_B_BIT] = fc_drive_bus_b_bit;
				rd[CT_DRIVE_BUS_A_BIT] = fc_drive_bus_a_bit;
				rd[CT_PIN] = ext_s2; // RULE3 RULE15
				rd[CT_CLK +: 3] = fc_clk;
			end
			OFS_FCNT: rd = fc_count; // RULE11
			OFS_MCTL: begin
				rd[CT_COF] = mc_cof;
				rd[CT_IL +: 3] = mc_il;
				rd[CT_ARB3] = mc_arb3;
				rd[CT_DRIVE_BUS_B_BIT] = mc_drive_bus_b_bit;
				rd[CT_DRIVE_BUS_A_BIT] = mc_drive_bus_a_bit;
				rd[CT_PIN] = ext_s2; // RULE3
				rd[CT_PIN1] = ld_s2; // RULE3
				rd[CT_EDGE +: 2] = mc_edge;
				rd[CT_CLK +: 3] = mc_clk;
			end
			OFS_MCNT: rd = mc_count;
			OFS_MLAT: rd = mc_latch;
			default: rd = REG_RST; // RULE8
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			prdata <= {16'h0000, rd}; // RULE8
		end
	end

	// Bus unit configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freeze_response_bit <= 1'b0;
			vector_upper_bits <= 2'h0;
			arbitration_field <= 3'h0;
		end else if (wr_bucfg) begin
			freeze_response_bit <= wd[BU_FRZ];
			vector_upper_bits <= wd[BU_VECT +: 2];
			arbitration_field <= wd[BU_IARB +: 3];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescaler_run_bit <= 1'b0; // RULE13
			div_sel <= 2'h0;
		end else if (wr_psctl) begin
			prescaler_run_bit <= wd[PS_RUN];
			div_sel <= wd[PS_DIV +: 2];
		end
	end

	// Divider chain; restarts from zero whenever software stops it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt <= '0;
		end else if (!prescaler_run_bit) begin
			pre_cnt <= '0;
		end else if (run) begin
			pre_cnt <= pre_cnt + 1'b1; // RULE2 RULE9
		end
	end

	// Tap k pulses once every 2^(k+1) cycles
	generate
		for (genvar k = 0; k < 5; k++) begin : g_tap
			assign tick[k] = run && (&pre_cnt[k:0]); // RULE9
		end
	endgenerate
	// Sixth tap built apart so that each bit of tick has one kind of driver
	always_comb begin
		unique case (div_sel)
			2'h0: tap6 = run && (&pre_cnt[5:0]); // RULE9
			2'h1: tap6 = run && (&pre_cnt[6:0]);
			2'h2: tap6 = run && (&pre_cnt[7:0]);
			2'h3: tap6 = run && (&pre_cnt[8:0]);
		endcase
	end
	assign tick[5] = tap6; // RULE9

	// Pin synchronisers; a third stage feeds the edge detectors
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
			ld_s1 <= 1'b0;
			ld_s2 <= 1'b0;
			ld_s3 <= 1'b0;
		end else begin
			ext_s1 <= ext_counter_clock_pin; // RULE15
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			ld_s1 <= mod_load_pin;
			ld_s2 <= ld_s1;
			ld_s3 <= ld_s2;
		end
	end
	// Edges only resolve if the pin stays below a quarter of pclk (RULE16)
	assign ext_rise = ext_s2 && !ext_s3;
	assign ext_fall = !ext_s2 && ext_s3;
	assign ld_rise = ld_s2 && !ld_s3;
	assign ld_fall = !ld_s2 && ld_s3;
	assign load_evt = (mc_edge[0] && ld_rise) || (mc_edge[1] && ld_fall); // RULE20

	// Counter control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fc_il <= 3'h0;
			fc_arb3 <= 1'b0;
			fc_drive_bus_a_bit <= 1'b0;
			fc_drive_bus_b_bit <= 1'b0;
			fc_clk <= 3'h0;
		end else if (wr_fctl) begin
			fc_il <= wd[CT_IL +: 3]; // RULE18
			fc_arb3 <= wd[CT_ARB3];
			fc_drive_bus_a_bit <= wd[CT_DRIVE_BUS_A_BIT];
			fc_drive_bus_b_bit <= wd[CT_DRIVE_BUS_B_BIT];
			fc_clk <= wd[CT_CLK +: 3]; // RULE14
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mc_il <= 3'h0;
			mc_arb3 <= 1'b0;
			mc_drive_bus_a_bit <= 1'b0;
			mc_drive_bus_b_bit <= 1'b0;
			mc_edge <= 2'h0;
			mc_clk <= 3'h0;
		end else if (wr_mctl) begin
			mc_il <= wd[CT_IL +: 3];
			mc_arb3 <= wd[CT_ARB3];
			mc_drive_bus_a_bit <= wd[CT_DRIVE_BUS_A_BIT];
			mc_drive_bus_b_bit <= wd[CT_DRIVE_BUS_B_BIT];
			mc_edge <= wd[CT_EDGE +: 2];
			mc_clk <= wd[CT_CLK +: 3]; // RULE14
		end
	end

	// Overflow flags: writing zero clears, a new overflow wins the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fc_cof <= 1'b0;
			mc_cof <= 1'b0;
		end else begin
			if (fc_ovf) begin
				fc_cof <= 1'b1; // RULE10
			end else if (wr_fctl && !wd[CT_COF]) begin
				fc_cof <= 1'b0;
			end
			if (mc_ovf) begin
				mc_cof <= 1'b1; // RULE23
			end else if (wr_mctl && !wd[CT_COF]) begin
				mc_cof <= 1'b0;
			end
		end
	end

	counter_core #(.MODULUS(1'b0)) u_free (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.ext_rise(ext_rise),
		.ext_fall(ext_fall),
		.clk_sel(fc_clk),
		.run(run),
		.load_evt(1'b0),
		.wr_cnt(wr_fcnt),
		.wr_lat(1'b0),
		.wdata(wd),
		.count(fc_count),
		.latch(fc_unused_lat),
		.ovf(fc_ovf)
	);

	counter_core #(.MODULUS(1'b1)) u_mod (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.ext_rise(ext_rise),
		.ext_fall(ext_fall),
		.clk_sel(mc_clk),
		.run(run),
		.load_evt(load_evt),
		.wr_cnt(wr_mcnt),
		.wr_lat(wr_mlat),
		.wdata(wd),
		.count(mc_count),
		.latch(mc_latch),
		.ovf(mc_ovf)
	);

	// Wired-OR time buses; both drive bits set is a software fault (RULE17)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tbb_a <= CNT_RST;
			tbb_b <= CNT_RST;
		end else begin
			tbb_a <= (fc_drive_bus_a_bit ? fc_count : CNT_RST) | (mc_drive_bus_a_bit ? mc_count : CNT_RST);
			tbb_b <= (fc_drive_bus_b_bit ? fc_count : CNT_RST) | (mc_drive_bus_b_bit ? mc_count : CNT_RST);
		end
	end

	// Interrupt forwarding and acknowledge
	assign fc_req = fc_cof && (fc_il != 3'h0); // RULE18
	assign mc_req = mc_cof && (mc_il != 3'h0);
	assign irq_req = fc_req || mc_req; // RULE22
	always_comb begin
		irq_level = 3'h0;
		if (fc_req) begin
			irq_level = fc_il;
		end
		if (mc_req && (!fc_req || mc_il > fc_il)) begin
			irq_level = mc_il; // RULE22
		end
	end
	assign fc_match = fc_req && fc_il == iack_level;
	assign mc_match = mc_req && mc_il == iack_level;
	// Ties on the fourth arbitration bit go to the free-running counter
	assign fc_win = fc_match && !(mc_match && mc_arb3 && !fc_arb3); // RULE18

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iack_hit <= 1'b0;
			iack_arb <= 4'h0;
			iack_vector <= 8'h00;
		end else begin
			iack_hit <= iack_valid && (fc_match || mc_match); // RULE22
			if (iack_valid && fc_win) begin
				iack_arb <= {fc_arb3, arbitration_field}; // RULE18
				iack_vector <= {vector_upper_bits, FC_NUM}; // RULE19
			end else if (iack_valid && mc_match) begin
				iack_arb <= {mc_arb3, arbitration_field};
				iack_vector <= {vector_upper_bits, MC_NUM}; // RULE19
			end
		end
	end

	a_freeze_hold: assert property (@(posedge pclk) disable iff (!presetn)
		submodule_freeze && !wr_fcnt && !wr_mcnt ##1 !wr_fcnt && !wr_mcnt
		|-> $stable(pre_cnt) && $stable(fc_count) && $stable(mc_count))
		else $error("counter moved while frozen"); // RULE2
	a_freeze_ignore: assert property (@(posedge pclk) disable iff (!presetn)
		!freeze_response_bit |-> !submodule_freeze)
		else $error("freeze honoured with response bit clear"); // RULE6
	a_pin_track: assert property (@(posedge pclk) disable iff (!presetn)
		setup && paddr == OFS_MCTL ##1 1'b1 |->
		prdata[CT_PIN1] == $past(mod_load_pin, 3))
		else $error("load pin level bit not tracking"); // RULE3
	a_run_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!prescaler_run_bit && !wr_fcnt |=> $stable(fc_count))
		else $error("counter ran before run bit"); // RULE13
	a_cof_set: assert property (@(posedge pclk) disable iff (!presetn)
		fc_ovf |=> fc_cof)
		else $error("overflow flag lost"); // RULE10
	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		fc_cof && fc_il != 3'h0 |-> irq_req && irq_level >= fc_il)
		else $error("interrupt request or level wrong"); // RULE18
	a_vector_out: assert property (@(posedge pclk) disable iff (!presetn)
		iack_valid && fc_win |=> iack_hit && iack_vector == {$past(vector_upper_bits), FC_NUM})
		else $error("acknowledge vector wrong"); // RULE19
	a_tap_rate: assert property (@(posedge pclk) disable iff (!presetn)
		tick[0] |=> !tick[0])
		else $error("first tap not divide by two"); // RULE9
	a_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !hit |=> prdata == 32'h0000_0000)
		else $error("unmapped read not zero"); // RULE8

	c_overflow: cover property (@(posedge pclk) disable iff (!presetn) fc_ovf);
	c_reload: cover property (@(posedge pclk) disable iff (!presetn) load_evt && run);
	c_iack: cover property (@(posedge pclk) disable iff (!presetn) iack_hit);
	c_frozen: cover property (@(posedge pclk) disable iff (!presetn) submodule_freeze && run == 1'b0);
endmodule

/* sim/host_iack.sv */
// Host side model that answers timer interrupt requests
`timescale 1ns/1ps
module host_iack (
	input wire logic pclk,
	input wire logic [2:0] irq_level,
	input wire logic iack_hit,
	input wire logic [7:0] iack_vector,
	output logic iack_valid,
	output logic [2:0] iack_level
);
	initial begin
		iack_valid = 1'b0;
		iack_level = 3'h0;
	end
	// One-cycle acknowledge of the level now requested; the hit flag stands one cycle only
	task automatic ack(output logic hit, output logic [7:0] vec);
		@(posedge pclk);
		iack_valid <= 1'b1;
		iack_level <= irq_level;
		@(posedge pclk);
		iack_valid <= 1'b0;
		iack_level <= 3'h0;
		@(posedge pclk);
		hit = iack_hit;
		vec = iack_vector;
	endtask
endmodule

/* sim/tb.sv */
// Self-checking testbench for the timer core
`timescale 1ns/1ps
module tb;
	import timer_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic sys_freeze = 1'b0;
	logic ext_pin = 1'b0;
	logic load_pin = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, submodule_freeze, irq_req, iack_valid, iack_hit;
	logic [15:0] tbb_a, tbb_b;
	logic [2:0] irq_level, iack_level;
	logic [3:0] iack_arb;
	logic [7:0] iack_vector;
	logic [31:0] q, q2;
	logic e;
	logic [7:0] vec;
	int miscompares = 0;
	int total_checks = 0;

	always #12.5 pclk = ~pclk;

	timer_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sys_freeze(sys_freeze), .ext_counter_clock_pin(ext_pin),
		.mod_load_pin(load_pin), .submodule_freeze(submodule_freeze), .tbb_a(tbb_a),
		.tbb_b(tbb_b), .irq_req(irq_req), .irq_level(irq_level), .iack_valid(iack_valid),
		.iack_level(iack_level), .iack_hit(iack_hit), .iack_arb(iack_arb),
		.iack_vector(iack_vector));

	host_iack u_host (.pclk(pclk), .irq_level(irq_level), .iack_hit(iack_hit),
		.iack_vector(iack_vector), .iack_valid(iack_valid), .iack_level(iack_level));

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Setup cycle, then access held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			miscompares++;
			summarize();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'h0000, d});
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task automatic t_reset;
		rd(OFS_FCNT);
		chk("fcnt reset", 32'h0000_0000, q);
		rd(OFS_MLAT);
		chk("mlat reset", 32'h0000_0000, q);
		rd(8'h04);
		chk("reserved read", 32'h0000_0000, q);
		chk("reserved err", 32'h0000_0001, {31'h0, e});
		wr(8'h04, 16'hFFFF);
		wr(OFS_PSCTL, 16'hFFFF);
		rd(OFS_PSCTL);
		chk("psctl unused bits", 32'h0000_000B, q);
		wr(OFS_PSCTL, 16'h0000);
		wr(OFS_FCNT, 16'h1234);
		cyc(40);
		rd(OFS_FCNT);
		chk("fcnt idle without run", 32'h0000_1234, q);
		wr(OFS_FCTL, 16'h0100);
		cyc(3);
		chk("tbb_a driven", 32'h0000_1234, {16'h0, tbb_a});
		chk("tbb_b idle", 32'h0000_0000, {16'h0, tbb_b});
	endtask

	task automatic t_taps;
		int lo;
		wr(OFS_PSCTL, 16'h0008);
		for (int c = 0; c < 6; c++) begin
			wr(OFS_FCTL, c[15:0]);
			wr(OFS_FCNT, 16'h0000);
			cyc(150);
			rd(OFS_FCNT);
			// Read captures the count 151 edges after the load; tap c divides by 2^(c+1)
			lo = 151 >> (c + 1);
			chk("tap rate", 32'h1, {31'h0, (q >= lo && q <= lo + 1)});
		end
	endtask

	// External edges kept well below a quarter of pclk
	task automatic t_ext;
		for (int c = 6; c < 8; c++) begin
			wr(OFS_FCTL, c[15:0]);
			wr(OFS_FCNT, 16'h0000);
			repeat (5) begin
				ext_pin <= 1'b1;
				cyc(4);
				rd(OFS_FCTL);
				chk("pin mirror", 32'h1, {31'h0, q[CT_PIN]});
				ext_pin <= 1'b0;
				cyc(4);
			end
			cyc(6);
			rd(OFS_FCNT);
			chk("edge count", 32'h0000_0005, q);
		end
	endtask

	task automatic t_freeze;
		wr(OFS_FCTL, 16'h0000);
		wr(OFS_BUCFG, 16'h8000);
		sys_freeze <= 1'b1;
		ext_pin <= 1'b1;
		cyc(6);
		chk("freeze out", 32'h1, {31'h0, submodule_freeze});
		rd(OFS_FCNT);
		q2 = q;
		cyc(20);
		rd(OFS_FCNT);
		chk("frozen count", q2, q);
		rd(OFS_MCTL);
		chk("pin bit frozen", 32'h1, {31'h0, q[CT_PIN]});
		wr(OFS_BUCFG, 16'h0000);
		cyc(2);
		chk("freeze ignored", 32'h0, {31'h0, submodule_freeze});
		rd(OFS_FCNT);
		chk("counts unfrozen", 32'h1, {31'h0, q !== q2});
		sys_freeze <= 1'b0;
		ext_pin <= 1'b0;
	endtask

	task automatic t_irq;
		wr(OFS_BUCFG, 16'h0085);
		wr(OFS_FCTL, 16'h3000);
		wr(OFS_FCNT, 16'hFFF8);
		cyc(40);
		rd(OFS_FCTL);
		chk("overflow flag", 32'h1, {31'h0, q[CT_COF]});
		chk("irq req", 32'h1, {31'h0, irq_req});
		chk("irq level", 32'h3, {29'h0, irq_level});
		u_host.ack(e, vec);
		chk("ack hit", 32'h1, {31'h0, e});
		chk("vector", 32'h8C, {24'h0, vec});
		chk("arb", 32'h5, {28'h0, iack_arb});
		wr(OFS_FCTL, 16'h3000);
		cyc(2);
		chk("irq cleared", 32'h0, {31'h0, irq_req});
		wr(OFS_PSCTL, 16'h0000);
		wr(OFS_FCNT, 16'hFFFF);
		wr(OFS_FCNT, 16'h0000);
		cyc(5);
		rd(OFS_FCTL);
		chk("silent zero write", 32'h0, {30'h0, q[CT_COF], irq_req});
	endtask

	task automatic t_mod;
		wr(OFS_MCNT, 16'hABCD);
		rd(OFS_MLAT);
		chk("latch from counter write", 32'h0000_ABCD, q);
		wr(OFS_MCTL, 16'h0016);
		wr(OFS_MLAT, 16'h0055);
		// Pin reloads only take effect while the prescaler runs
		wr(OFS_PSCTL, 16'h0008);
		load_pin <= 1'b1;
		cyc(6);
		rd(OFS_MCNT);
		chk("pin reload", 32'h0000_0055, q);
		rd(OFS_MCTL);
		chk("load pin bit", 32'h1, {31'h0, q[CT_PIN1]});
		wr(OFS_PSCTL, 16'h0008);
		wr(OFS_MCTL, 16'h0000);
		wr(OFS_MLAT, 16'h0100);
		wr(OFS_MCNT, 16'hFFF8);
		wr(OFS_MLAT, 16'h0100);
		cyc(40);
		rd(OFS_MCNT);
		chk("wrap reload", 32'h1, {31'h0, (q[15:0] >= 16'h0100 && q[15:0] < 16'h0140)});
		wr(OFS_MCNT, 16'hFFFF);
		cyc(10);
		wr(OFS_MCTL, 16'h0000);
		cyc(6);
		rd(OFS_MCTL);
		chk("top latch flag", 32'h1, {31'h0, q[CT_COF]});
		wr(OFS_MCTL, 16'h2800);
		cyc(4);
		chk("mod irq level", 32'h2, {29'h0, irq_level});
		u_host.ack(e, vec);
		chk("mod ack hit", 32'h1, {31'h0, e});
		chk("mod vector", 32'h8B, {24'h0, vec});
		chk("mod arb", 32'hD, {28'h0, iack_arb});
	endtask

	initial begin
		cyc(6);
		presetn <= 1'b1;
		t_reset();
		t_taps();
		t_ext();
		t_freeze();
		t_irq();
		t_mod();
		summarize();
	end
endmodule
